// ==== core/smpr_consts.svh ====
/*
 * Constants of the multi-lane serial pin-role block.
 * Assumes inclusion by the package and the top file only.
 */
`ifndef SMPR_CONSTS_SVH
`define SMPR_CONSTS_SVH

// ----------------------------------------
// Widths, FIFO depth and idle word
// ----------------------------------------
`define SMPR_WORD_W 8
`define SMPR_LANE_N 4
`define SMPR_BITCNT_W 3
`define SMPR_FIFO_DEPTH 4
`define SMPR_IDLE_WORD 8'hFF

// ----------------------------------------
// Pin positions
// ----------------------------------------
`define SMPR_PIN_LANE_TWO 2
`define SMPR_PIN_LANE_THREE 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMPR_CLK_PERIOD_NS 25
`define SMPR_T_RP_NS 100
`define SMPR_RP_CYCLES \
	((`SMPR_T_RP_NS + `SMPR_CLK_PERIOD_NS - 1) / `SMPR_CLK_PERIOD_NS)

`endif

// ==== core/smpr_pkg.sv ====
/*
 * Types of the multi-lane serial pin-role block.
 * Assumes the constants header is on the include path.
 */
`include "smpr_consts.svh"

package smpr_pkg;

	// ----------------------------------------
	// Modes and states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SMPR_W1 = 2'h0,
		SMPR_W2 = 2'h1,
		SMPR_W4 = 2'h2
	} smpr_width_t;

	typedef enum logic [1:0] {
		SMPR_RS_IDLE  = 2'h0,
		SMPR_RS_COUNT = 2'h1,
		SMPR_RS_HOLD  = 2'h2
	} smpr_rst_state_t;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic quad_enable_bit;
		logic status_write_disable_bit;
		logic pin_restart_enable_bit;
	} smpr_cfg_t;

	typedef struct packed {
		logic [`SMPR_LANE_N-1:0] o;
		logic [`SMPR_LANE_N-1:0] oe;
	} smpr_pad_t;

	// ----------------------------------------
	// State records
	// ----------------------------------------
	typedef struct packed {
		logic [1:0]             cs_s;
		logic [1:0]             io2_s;
		logic [1:0]             io3_s;
		logic [1:0]             rx_tgl_s;
		logic [1:0]             tx_ack_s;
		logic                   rx_seen;
		logic                   rx_pend;
		logic                   rx_overrun;
		logic [`SMPR_WORD_W-1:0] rx_buf;
		logic                   tx_tgl;
		logic                   tx_pend;
		logic [`SMPR_WORD_W-1:0] tx_word;
		logic                   wp_role;
		logic                   write_protect;
		logic                   rst_role;
		logic                   hw_restart;
		smpr_rst_state_t        rst_st;
		logic [7:0]             rst_cnt;
	} smpr_sys_t;

	typedef struct packed {
		logic [`SMPR_WORD_W-1:0]   sh;
		logic [`SMPR_BITCNT_W-1:0] cnt;
		logic [`SMPR_WORD_W-1:0]   hold;
		logic                      tgl;
		logic [1:0]                qe_s;
	} smpr_rise_t;

	typedef struct packed {
		logic [`SMPR_WORD_W-1:0]   sh;
		logic [`SMPR_BITCNT_W-1:0] cnt;
		logic [1:0]                txt_s;
		logic                      ack;
	} smpr_fall_t;

	typedef struct packed {
		smpr_pad_t pad;
		logic      started;
	} smpr_frame_t;

endpackage : smpr_pkg

// ==== core/smpr_top.sv ====
/*
 * Pin-role logic and lane shifter of a multi-lane serial flash port,
 * with its receive FIFO.
 * Assumes a command decoder on the serial clock sets width and direction,
 * and same-clock logic supplies the configuration bits.
 */
`timescale 1ns/1ps
`include "smpr_consts.svh"

// ----------------------------------------
// Shift-style FIFO, head always in slot 0
// ----------------------------------------
module smpr_fifo #(
	parameter int W = 8,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         arst_n,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int CW = $clog2(D) + 1;

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [CW-1:0]       cnt;
		logic                vld;
		logic                rdy;
	} smpr_fifo_st_t;

	smpr_fifo_st_t q, d;
	logic [CW-1:0] n;

	always_comb begin
		d = q;
		n = q.cnt;
		if (q.vld && out_ready) begin
			for (int i = 0; i < D - 1; i++) begin
				d.mem[i] = q.mem[i + 1];
			end
			n = CW'(q.cnt - 1'b1);
		end
		d.cnt = n;
		if (in_valid && q.rdy) begin
			d.mem[n] = in_data;
			d.cnt = CW'(n + 1'b1);
		end
		// Flags registered so both handshakes leave flops
		d.vld = d.cnt != '0;
		d.rdy = d.cnt != CW'(D);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
			q.rdy <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign in_ready  = q.rdy;
	assign out_valid = q.vld;
	assign out_data  = q.mem[0];
endmodule : smpr_fifo

// ----------------------------------------
// Top
// ----------------------------------------
module smpr_top
	import smpr_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    sck,
	input  wire logic                    cs_n,
	input  wire logic [`SMPR_LANE_N-1:0] io_i,
	output smpr_pad_t                    pad,
	input  wire smpr_cfg_t               cfg,
	input  wire smpr_width_t             link_width,
	input  wire logic                    link_dir_out,
	output logic                         rx_valid,
	output logic [`SMPR_WORD_W-1:0]      rx_data,
	input  wire logic                    rx_ready,
	output logic                         rx_overrun,
	input  wire logic                    rx_overrun_clr,
	input  wire logic                    tx_valid,
	input  wire logic [`SMPR_WORD_W-1:0] tx_data,
	output logic                         tx_ready,
	output logic                         wp_role,
	output logic                         write_protect,
	output logic                         restart_role,
	output logic                         hw_restart
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Quad without quad enable falls back to one lane
	function automatic smpr_width_t smpr_eff_width(
		input smpr_width_t w,
		input logic        qe
	);
		if (w == SMPR_W4 && qe) begin
			return SMPR_W4;
		end else if (w == SMPR_W2) begin
			return SMPR_W2;
		end else begin
			return SMPR_W1;
		end
	endfunction : smpr_eff_width

	function automatic logic [`SMPR_BITCNT_W-1:0] smpr_step(
		input smpr_width_t w
	);
		case (w)
			SMPR_W4: return 3'h4;
			SMPR_W2: return 3'h2;
			default: return 3'h1;
		endcase
	endfunction : smpr_step

	smpr_sys_t   sys_q, sys_d;
	smpr_rise_t  rise_q, rise_d;
	smpr_fall_t  fall_q, fall_d;
	smpr_frame_t frm_q, frm_d;
	logic        rise_started_q;
	logic        frame_rst_n;
	logic        fifo_in_ready;
	smpr_width_t w_r;
	smpr_width_t w_f;
	logic [`SMPR_BITCNT_W-1:0] cnt_r;
	logic [`SMPR_BITCNT_W-1:0] cnt_f;
	logic [`SMPR_WORD_W-1:0]   sh_f;
	logic        rst_cond;

	// Deselect clears frame state at once, clock or not
	assign frame_rst_n = arst_n & ~cs_n;

	// ----------------------------------------
	// Link, rising edge: sampling
	// ----------------------------------------
	always_comb begin
		rise_d = rise_q;
		rise_d.qe_s = {rise_q.qe_s[0], cfg.quad_enable_bit};
		w_r = smpr_eff_width(link_width, rise_q.qe_s[1]);
		cnt_r = rise_started_q ? rise_q.cnt : '0;
		if (!link_dir_out) begin
			case (w_r)
				SMPR_W4: rise_d.sh = {rise_q.sh[3:0], io_i};
				SMPR_W2: rise_d.sh = {rise_q.sh[5:0], io_i[1:0]};
				default: rise_d.sh = {rise_q.sh[6:0], io_i[0]};
			endcase
			rise_d.cnt = cnt_r + smpr_step(w_r);
			if (rise_d.cnt == '0) begin
				rise_d.hold = rise_d.sh;
				rise_d.tgl  = ~rise_q.tgl;
			end
		end
	end

	always_ff @(posedge sck or negedge arst_n) begin
		if (!arst_n) begin
			rise_q <= '0;
		end else begin
			rise_q <= rise_d;
		end
	end

	// First edge of a frame restarts the bit count
	always_ff @(posedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			rise_started_q <= 1'b0;
		end else begin
			rise_started_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Link, falling edge: driving
	// ----------------------------------------
	always_comb begin
		fall_d = fall_q;
		frm_d  = frm_q;
		frm_d.started = 1'b1;
		fall_d.txt_s = {fall_q.txt_s[0], sys_q.tx_tgl};
		w_f = smpr_eff_width(link_width, rise_q.qe_s[1]);
		cnt_f = frm_q.started ? fall_q.cnt : '0;
		sh_f = fall_q.sh;
		frm_d.pad = '0;
		if (!link_dir_out) begin
			fall_d.cnt = '0;
		end else begin
			if (cnt_f == '0) begin
				// Idle ones when no word waits, never stale data
				if (fall_q.txt_s[1] != fall_q.ack) begin
					sh_f = sys_q.tx_word;
					fall_d.ack = ~fall_q.ack;
				end else begin
					sh_f = `SMPR_IDLE_WORD;
				end
			end
			case (w_f)
				SMPR_W4: begin
					frm_d.pad.o  = sh_f[7:4];
					frm_d.pad.oe = 4'hF;
					fall_d.sh = {sh_f[3:0], 4'h0};
				end
				SMPR_W2: begin
					frm_d.pad.o  = {2'h0, sh_f[7:6]};
					frm_d.pad.oe = 4'h3;
					fall_d.sh = {sh_f[5:0], 2'h0};
				end
				default: begin
					frm_d.pad.o  = {2'h0, sh_f[7], 1'b0};
					frm_d.pad.oe = 4'h2;
					fall_d.sh = {sh_f[6:0], 1'b0};
				end
			endcase
			fall_d.cnt = cnt_f + smpr_step(w_f);
		end
	end

	always_ff @(negedge sck or negedge arst_n) begin
		if (!arst_n) begin
			fall_q <= '0;
		end else begin
			fall_q <= fall_d;
		end
	end

	// Pads release the moment select goes high
	always_ff @(negedge sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			frm_q <= '0;
		end else begin
			frm_q <= frm_d;
		end
	end

	// ----------------------------------------
	// System clock: roles, restart, crossings
	// ----------------------------------------
	always_comb begin
		sys_d = sys_q;
		sys_d.cs_s     = {sys_q.cs_s[0], cs_n};
		sys_d.io2_s    = {sys_q.io2_s[0], io_i[`SMPR_PIN_LANE_TWO]};
		sys_d.io3_s    = {sys_q.io3_s[0], io_i[`SMPR_PIN_LANE_THREE]};
		sys_d.rx_tgl_s = {sys_q.rx_tgl_s[0], rise_q.tgl};
		sys_d.tx_ack_s = {sys_q.tx_ack_s[0], fall_q.ack};

		sys_d.wp_role = ~cfg.quad_enable_bit
			& cfg.status_write_disable_bit;
		// Pin level only counts while selected and in role
		sys_d.write_protect = sys_d.wp_role & ~sys_q.cs_s[1]
			& ~sys_q.io2_s[1];
		sys_d.rst_role = cfg.pin_restart_enable_bit
			& (~cfg.quad_enable_bit | sys_q.cs_s[1]);

		rst_cond = sys_d.rst_role & sys_q.cs_s[1] & ~sys_q.io3_s[1];
		sys_d.hw_restart = 1'b0;
		case (sys_q.rst_st)
			SMPR_RS_IDLE: begin
				if (rst_cond) begin
					sys_d.rst_st  = SMPR_RS_COUNT;
					sys_d.rst_cnt = 8'h01;
				end
			end
			SMPR_RS_COUNT: begin
				if (!rst_cond) begin
					sys_d.rst_st = SMPR_RS_IDLE;
				end else if (sys_q.rst_cnt >= 8'(`SMPR_RP_CYCLES)) begin
					sys_d.hw_restart = 1'b1;
					sys_d.rst_st     = SMPR_RS_HOLD;
				end else begin
					sys_d.rst_cnt = 8'(sys_q.rst_cnt + 8'h01);
				end
			end
			SMPR_RS_HOLD: begin
				// One pulse per low period
				if (!rst_cond) begin
					sys_d.rst_st = SMPR_RS_IDLE;
				end
			end
			default: sys_d.rst_st = SMPR_RS_IDLE;
		endcase

		// Received word waits here while the FIFO is full
		if (sys_q.rx_pend && fifo_in_ready) begin
			sys_d.rx_pend = 1'b0;
		end
		if (rx_overrun_clr) begin
			sys_d.rx_overrun = 1'b0;
		end
		if (sys_q.rx_tgl_s[1] != sys_q.rx_seen) begin
			sys_d.rx_seen = sys_q.rx_tgl_s[1];
			// Set beats clear in the same cycle
			if (sys_d.rx_pend) begin
				sys_d.rx_overrun = 1'b1;
			end
			sys_d.rx_pend = 1'b1;
			sys_d.rx_buf  = rise_q.hold;
		end

		if (sys_q.tx_pend && sys_q.tx_ack_s[1] == sys_q.tx_tgl) begin
			sys_d.tx_pend = 1'b0;
		end
		if (tx_valid && !sys_q.tx_pend) begin
			sys_d.tx_word = tx_data;
			sys_d.tx_pend = 1'b1;
			sys_d.tx_tgl  = ~sys_q.tx_tgl;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sys_q <= '0;
			sys_q.cs_s  <= 2'h3;
			sys_q.io2_s <= 2'h3;
			sys_q.io3_s <= 2'h3;
		end else begin
			sys_q <= sys_d;
		end
	end

	// ----------------------------------------
	// Receive FIFO
	// ----------------------------------------
	smpr_fifo #(
		.W (`SMPR_WORD_W),
		.D (`SMPR_FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.arst_n    (arst_n),
		.in_valid  (sys_q.rx_pend),
		.in_data   (sys_q.rx_buf),
		.in_ready  (fifo_in_ready),
		.out_valid (rx_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pad           = frm_q.pad;
	assign rx_overrun    = sys_q.rx_overrun;
	assign tx_ready      = ~sys_q.tx_pend;
	assign wp_role       = sys_q.wp_role;
	assign write_protect = sys_q.write_protect;
	assign restart_role  = sys_q.rst_role;
	assign hw_restart    = sys_q.hw_restart;

endmodule : smpr_top

// ==== testbench/smpr_host_model.sv ====
/* Host serial controller model: clock, select and lane drivers.
   Assumes one task call at a time; lanes resolved here. */
`timescale 1ns/1ps
module smpr_host_model
	import smpr_pkg::*;
(
	input  wire smpr_pad_t pad,
	output logic           sck,
	output logic           cs_n,
	output logic [3:0]     io_i
);
	logic [3:0] hoe, hdo;
	logic       flt;
	int         half;

	initial begin
		{sck, hoe, hdo, flt} = '0;
		cs_n = 1'b1;
		half = 80;
		forever #25 flt = ~flt;
	end

	// Pull-ups on two and three; zero and one wander when released
	always_comb
		for (int k = 0; k < 4; k++)
			io_i[k] = hoe[k] ? hdo[k] : pad.oe[k] ? pad.o[k] : (k > 1) || flt;

	// Firm levels, clock still
	task automatic pins(input logic c, input logic [3:0] oe,
		input logic [3:0] v);
		cs_n = c;
		hoe = oe;
		hdo = v;
	endtask : pins

	// One byte, w lanes, MSB first; a read takes a lead clock
	task automatic xfer(input int w, input logic rd, input logic [7:0] d,
		output logic [7:0] q);
		logic [3:0] m;
		int         n;
		m = 4'((1 << w) - 1);
		n = 8 / w + int'(rd);
		q = 8'h00;
		// Two clocks while deselected let the send toggle settle
		if (rd)
			repeat (2) begin
				#(half) sck = 1'b1;
				#(half) sck = 1'b0;
			end
		#(half) cs_n = 1'b0;
		hoe = rd ? 4'h0 : m;
		for (int i = 0; i < n; i++) begin
			if (!rd)
				hdo = 4'(d >> (8 - w * (i + 1)));
			#(half) sck = 1'b1;
			if (rd && i > 0)
				q = 8'((q << w) | ((w == 1 ? io_i >> 1 : io_i) & m));
			#(half) sck = 1'b0;
		end
		#(half) cs_n = 1'b1;
		hoe = 4'h0;
	endtask : xfer
endmodule : smpr_host_model

// ==== testbench/smpr_top_assertions.sv ====
/* Checker of pin roles, pads and receive port of smpr_top.
   Assumes the bind below; cfg stays still while a frame runs. */
`timescale 1ns/1ps
module smpr_top_assertions
	import smpr_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] io_i,
	input wire smpr_pad_t  pad,
	input wire smpr_cfg_t  cfg,
	input wire logic       rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic       rx_ready,
	input wire logic       wp_role,
	input wire logic       write_protect,
	input wire logic       restart_role,
	input wire logic       hw_restart
);
	// ----------------------------------------
	// Properties, all on the system clock
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_oe_idle; cs_n |-> pad.oe == 4'h0; endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("pads driven while deselected");
	property p_sdr;
		!cs_n && $past(!cs_n) && $changed(pad.o) |-> !sck;
	endproperty
	a_sdr: assert property (p_sdr)
		else $error("pad moved while serial clock high");
	property p_lane_hi; |pad.oe[3:2] |-> cfg.quad_enable_bit; endproperty
	a_lane_hi: assert property (p_lane_hi)
		else $error("upper lanes driven without quad");
	property p_wp_role; $stable(cfg) [*3] |->
		wp_role == (!cfg.quad_enable_bit && cfg.status_write_disable_bit);
	endproperty
	a_wp_role: assert property (p_wp_role)
		else $error("write protect role wrong");
	property p_wp_off; !wp_role [*2] |-> !write_protect; endproperty
	a_wp_off: assert property (p_wp_off)
		else $error("protect without role");
	property p_wp_idle; cs_n [*5] |-> !write_protect; endproperty
	a_wp_idle: assert property (p_wp_idle)
		else $error("protect while deselected");
	property p_wp_on;
		(wp_role && !cs_n && !io_i[2]) [*5] |-> write_protect;
	endproperty
	a_wp_on: assert property (p_wp_on)
		else $error("protect missed");
	property p_rr_off;
		!cfg.pin_restart_enable_bit [*3] |-> !restart_role;
	endproperty
	a_rr_off: assert property (p_rr_off)
		else $error("restart role while disabled");
	property p_rr_on; (cfg.pin_restart_enable_bit &&
		!cfg.quad_enable_bit) [*3] |-> restart_role;
	endproperty
	a_rr_on: assert property (p_rr_on)
		else $error("restart role missing");
	property p_hw_one; hw_restart |=> !hw_restart; endproperty
	a_hw_one: assert property (p_hw_one)
		else $error("restart pulse too long");
	property p_hw_why; hw_restart |->
		$past(cs_n && !io_i[3], 3) && $past(restart_role);
	endproperty
	a_hw_why: assert property (p_hw_why)
		else $error("restart without cause");
	property p_rx_hold;
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
	endproperty
	a_rx_hold: assert property (p_rx_hold)
		else $error("receive word dropped");
endmodule : smpr_top_assertions

bind smpr_top smpr_top_assertions i_chk (.clk, .arst_n, .sck, .cs_n,
	.io_i, .pad, .cfg, .rx_valid, .rx_data, .rx_ready, .wp_role,
	.write_protect, .restart_role, .hw_restart);

// ==== testbench/smpr_top_test.sv ====
/* Self-checking bench of smpr_top with a queue model of receive data.
   Assumes host model and checker are compiled before it. */
`timescale 1ns/1ps
module smpr_top_test
	import smpr_pkg::*;
;
	logic        clk, arst_n, sck, cs_n, link_dir_out, wp;
	logic        rx_valid, rx_ready, rx_overrun, rx_overrun_clr;
	logic        tx_valid, tx_ready, wp_role, write_protect;
	logic        restart_role, hw_restart;
	logic [3:0]  io_i;
	logic [7:0]  rx_data, tx_data, d, q;
	logic [31:0] seed;
	smpr_pad_t   pad;
	smpr_cfg_t   cfg;
	smpr_width_t link_width;
	int          miscompares, checks_done, n_rst, cyc, n0;
	int          rxq[$];
	int          rc[5] = '{5, 5, 0, 5, 1};
	int          rs[5] = '{1, 1, 1, 0, 1};
	int          rl[5] = '{12, 3, 12, 12, 12};
	int          re[5] = '{1, 0, 0, 0, 1};

	smpr_top i_dut (.clk, .arst_n, .sck, .cs_n, .io_i, .pad, .cfg,
		.link_width, .link_dir_out, .rx_valid, .rx_data, .rx_ready,
		.rx_overrun, .rx_overrun_clr, .tx_valid, .tx_data, .tx_ready,
		.wp_role, .write_protect, .restart_role, .hw_restart);
	smpr_host_model i_host (.pad, .sck, .cs_n, .io_i);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic check(input logic [7:0] got, input logic [7:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m,
				got, exp);
		end
	endtask : check

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Monitors at the falling edge, where all is settled
	// ----------------------------------------
	always @(negedge clk) begin
		cyc++;
		if (hw_restart === 1'b1)
			n_rst++;
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
			check(rx_data, rxq.size() ? 8'(rxq.pop_front()) : 8'hXX, "rx");
		if (cyc == 5000) begin
			miscompares++;
			test_done();
		end
	end

	initial begin
		seed = 32'h0000005B;
		{miscompares, checks_done, n_rst, cyc, arst_n} = '0;
		cfg = '0;
		link_width = SMPR_W1;
		{link_dir_out, rx_ready, rx_overrun_clr, tx_valid} = '0;
		tx_data = 8'h00;
		tick(5);
		arst_n = 1'b1;
		tick(3);
		for (int c = 0; c < 8; c++) begin
			cfg = smpr_cfg_t'(3'(c));
			i_host.pins(1'b0, 4'h4, 4'h0);
			tick(8);
			wp = !cfg.quad_enable_bit && cfg.status_write_disable_bit;
			check(8'(wp_role), 8'(wp), "wp role");
			check(8'(write_protect), 8'(wp), "wp");
			check(8'(restart_role), 8'(cfg.pin_restart_enable_bit &&
				!cfg.quad_enable_bit), "rr sel");
			i_host.pins(1'b1, 4'h4, 4'h0);
			tick(8);
			check(8'(write_protect), 8'h00, "wp idle");
			check(8'(restart_role), 8'(cfg.pin_restart_enable_bit), "rr");
		end
		for (int i = 0; i < 5; i++) begin
			cfg = smpr_cfg_t'(3'(rc[i]));
			tick(4);
			n0 = n_rst;
			i_host.pins(1'(rs[i]), 4'h8, 4'h0);
			tick(rl[i]);
			i_host.pins(1'b1, 4'h0, 4'h0);
			tick(6);
			check(8'(n_rst - n0), 8'(re[i]), "restarts");
		end
		// Receive fill: FIFO full, one waits, next overwrites it
		cfg = smpr_cfg_t'(3'h4);
		tick(4);
		for (int i = 0; i < 6; i++) begin
			link_width = smpr_width_t'(i % 3);
			d = 8'(xs());
			i_host.half = (i == 5) ? 200 : 80;
			i_host.xfer(1 << (i % 3), 1'b0, d, q);
			if (i != 4)
				rxq.push_back(d);
			tick(10);
		end
		check(8'(rx_overrun), 8'h01, "overrun");
		rx_overrun_clr = 1'b1;
		tick();
		rx_overrun_clr = 1'b0;
		tick(2);
		check(8'(rx_overrun), 8'h00, "overrun clear");
		repeat (60) begin
			rx_ready = 1'(xs());
			tick();
		end
		rx_ready = 1'b1;
		tick(8);
		check(8'(rxq.size()), 8'h00, "rx drained");
		// Transmit at each width, then an idle byte
		link_dir_out = 1'b1;
		for (int i = 0; i < 4; i++) begin
			link_width = smpr_width_t'(i % 3);
			d = 8'hFF;
			if (i < 3) begin
				for (int k = 0; k < 40 && tx_ready !== 1'b1; k++)
					tick();
				d = 8'(xs());
				tx_valid = 1'b1;
				tx_data = d;
				tick();
				tx_valid = 1'b0;
			end
			tick(4);
			i_host.xfer(1 << (i % 3), 1'b1, 8'h00, q);
			check(q, d, "tx");
		end
		tick(4);
		test_done();
	end
endmodule : smpr_top_test
